/* logic/batmon_regs_pkg.sv */
/*
  Constants and types for the battery monitor control and status register bank.
  Assumes a byte-wide register port driven by the single-wire protocol engine.
*/
package batmon_regs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PROTECTION_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_STATUS = 8'h01;
  localparam logic [7:0] ADDR_NV_MEMORY_CTRL = 8'h07;
  localparam logic [7:0] ADDR_SPECIAL_FEATURE = 8'h08;

  // Protection register fields
  localparam int PROT_OVER_VOLTAGE = 7;
  localparam int PROT_UNDER_VOLTAGE = 6;
  localparam int PROT_CHARGE_OC = 5;
  localparam int PROT_DISCHARGE_OC = 4;
  localparam int PROT_CHARGE_MIRROR = 3;
  localparam int PROT_DISCHARGE_MIRROR = 2;
  localparam int PROT_CHARGE_ENABLE = 1;
  localparam int PROT_DISCHARGE_ENABLE = 0;

  // Status register fields
  localparam int STAT_SLEEP_ALLOW = 5;
  localparam int STAT_ALT_READ_ID = 4;
  localparam int STAT_SWAP_ENABLE = 3;
  localparam int STAT_IRQ_ENABLE = 2;
  localparam logic [7:0] STAT_CFG_MASK = 8'h3c;

  // Nonvolatile control register fields
  localparam int NVC_COPY_BUSY = 7;
  localparam int NVC_LOCK_ARM = 6;
  localparam int NVC_BLOCK1_LOCKED = 1;
  localparam int NVC_BLOCK0_LOCKED = 0;

  // Special feature register fields
  localparam int SPF_POWER_SWITCH = 7;
  localparam int SPF_PIN_IO = 6;
  localparam int SPF_SWAP_SELECTED = 5;

  // Identifier read opcodes
  localparam logic [7:0] OP_READ_ID_STD = 8'h33;
  localparam logic [7:0] OP_READ_ID_ALT = 8'h39;

  // Sleep entry time: bus low for longer than this
  localparam int SLEEP_LOW_MS = 2000;
  localparam int CLOCK_MHZ = 125;
  localparam longint SLEEP_LOW_CYCLES = longint'(SLEEP_LOW_MS) * 1000 * CLOCK_MHZ;

  // Protection fault events, one-cycle pulses
  typedef struct packed {
    logic over_voltage;
    logic under_voltage;
    logic charge_oc;
    logic discharge_oc;
  } fault_events_t;

  // Register write port from the protocol engine
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // Nonvolatile block 1 recall image
  typedef struct packed {
    logic valid;
    logic [7:0] prot_image;
    logic [7:0] status_image;
  } nv_recall_t;

endpackage

/* logic/battery_monitor_ctrl_status_regs.sv */
/*
  Control and status register bank of the battery monitor: protection,
  configuration status, nonvolatile control and special feature registers.
  Assumes a protocol engine on the same clock that delivers whole-byte writes,
  command pulses and recall images; the bus line and pins are synchronised here.
*/
// How it works
// - Fault flags sticky until host clears
// - Block 1 recall loads enable defaults
// - Bits 3,2 mirror control pins, read-only
// - Charge enable 0 forces charge output high
// - Discharge enable 0 forces discharge output high
// - Waking from sleep sets both enables
// - Block 1 recall loads status configuration
// - Sleep allow: bus low 2s sleeps
// - Status bit 4 picks identifier opcode
// - Swap command ignored unless enabled
// - Irq enable turns pin into interrupt
// - Status bits read-only, factory zero
// - Copy busy blocks nonvolatile writes
// - Lock needs arm bit, clears it
// - Block lock flags read-only
// - Power switch latch, write 1 clears
// - Pin bit senses and drives pin
// - Swap selected bit set by swap
// - Pin 0 pulls down; sleep releases
// - Interrupt pulls pin low on thresholds
module battery_monitor_ctrl_status_regs #(
  parameter longint SLEEP_CYCLES = batmon_regs_pkg::SLEEP_LOW_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register access from the protocol engine
  input wire batmon_regs_pkg::reg_write_t i_wr,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // Nonvolatile memory events
  input wire batmon_regs_pkg::nv_recall_t i_recall,
  input wire logic i_copy_start,
  input wire logic i_copy_done,
  input wire logic i_lock_cmd,
  input wire logic i_lock_block1,
  output logic o_nv_write_allow,
  // Protocol command events
  input wire logic i_swap_cmd,
  input wire logic i_swap_id_match,
  output logic o_swap_accept,
  output logic [7:0] o_read_id_opcode,
  // Protection inputs
  input wire batmon_regs_pkg::fault_events_t i_faults,
  input wire logic i_charge_protect,
  input wire logic i_discharge_protect,
  input wire logic i_threshold_alarm,
  // Pins
  input wire logic i_bus_line,
  input wire logic i_power_switch_n,
  input wire logic i_pin_io,
  output logic o_pin_io,
  output logic o_pin_io_oe,
  output logic o_charge_ctrl_n,
  output logic o_discharge_ctrl_n,
  output logic o_sleep
);

  localparam int SW = 48;

  // Synchronisers for pins
  logic [1:0] bus_sync_q, ps_sync_q, pio_sync_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bus_sync_q <= 2'h3;
      ps_sync_q <= 2'h3;
      pio_sync_q <= 2'h3;
    end else begin
      bus_sync_q <= {bus_sync_q[0], i_bus_line};
      ps_sync_q <= {ps_sync_q[0], i_power_switch_n};
      pio_sync_q <= {pio_sync_q[0], i_pin_io};
    end
  end
  logic bus_hi, ps_lo, pio_in;
  assign bus_hi = bus_sync_q[1];
  assign ps_lo = !ps_sync_q[1];
  assign pio_in = pio_sync_q[1];

  // Register storage
  logic [3:0] fault_q;
  logic charge_en_q, discharge_en_q;
  logic [7:0] status_q;
  logic copy_busy_q, lock_arm_q, block1_locked_q, block0_locked_q;
  logic ps_latch_q, pin_io_q, swap_sel_q;
  logic sleep_q;
  logic [SW-1:0] low_cnt_q;

  // Write decode
  logic wr_prot, wr_nvc, wr_spf, wake;
  assign wr_prot = i_wr.valid && i_wr.addr == batmon_regs_pkg::ADDR_PROTECTION_CTRL;
  assign wr_nvc = i_wr.valid && i_wr.addr == batmon_regs_pkg::ADDR_NV_MEMORY_CTRL;
  assign wr_spf = i_wr.valid && i_wr.addr == batmon_regs_pkg::ADDR_SPECIAL_FEATURE;

  // Sleep timer: bus low longer than the limit enters sleep
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      low_cnt_q <= '0;
    end else if (bus_hi || sleep_q) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q < SW'(SLEEP_CYCLES)) begin
      low_cnt_q <= low_cnt_q + SW'(1);
    end
  end

  // Sleep state, gated by the sleep allow bit
  assign wake = sleep_q && (bus_hi || ps_lo);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sleep_q <= 1'b0;
    end else if (!status_q[batmon_regs_pkg::STAT_SLEEP_ALLOW]) begin
      sleep_q <= 1'b0;
    end else if (wake) begin
      sleep_q <= 1'b0;
    end else if (!bus_hi && low_cnt_q >= SW'(SLEEP_CYCLES)) begin
      sleep_q <= 1'b1; // Count saturated while disallowed must not sleep a high bus
    end
  end

  // Sticky fault flags; a new event wins over the host clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fault_q <= '0;
    end else begin
      fault_q <= (wr_prot ? (fault_q & i_wr.data[7:4]) : fault_q) | i_faults;
    end
  end

  // Charge and discharge enables
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      charge_en_q <= 1'b1;
      discharge_en_q <= 1'b1;
    end else if (wake) begin
      charge_en_q <= 1'b1;
      discharge_en_q <= 1'b1;
    end else if (i_recall.valid) begin
      charge_en_q <= i_recall.prot_image[batmon_regs_pkg::PROT_CHARGE_ENABLE];
      discharge_en_q <= i_recall.prot_image[batmon_regs_pkg::PROT_DISCHARGE_ENABLE];
    end else if (wr_prot) begin
      charge_en_q <= i_wr.data[batmon_regs_pkg::PROT_CHARGE_ENABLE];
      discharge_en_q <= i_wr.data[batmon_regs_pkg::PROT_DISCHARGE_ENABLE];
    end
  end

  // Control outputs, active low; high when disabled or protected
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_charge_ctrl_n <= 1'b1;
      o_discharge_ctrl_n <= 1'b1;
    end else begin
      o_charge_ctrl_n <= !charge_en_q || i_charge_protect;
      o_discharge_ctrl_n <= !discharge_en_q || i_discharge_protect;
    end
  end

  // Status configuration, only from the recalled image
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      status_q <= '0;
    end else if (i_recall.valid) begin
      status_q <= i_recall.status_image & batmon_regs_pkg::STAT_CFG_MASK;
    end
  end

  // Copy busy flag
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      copy_busy_q <= 1'b0;
    end else if (i_copy_start) begin
      copy_busy_q <= 1'b1;
    end else if (i_copy_done) begin
      copy_busy_q <= 1'b0;
    end
  end
  assign o_nv_write_allow = !copy_busy_q;

  // Lock arm and block lock flags
  logic lock_go;
  assign lock_go = i_lock_cmd && lock_arm_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lock_arm_q <= 1'b0;
    end else if (lock_go) begin
      lock_arm_q <= 1'b0;
    end else if (wr_nvc) begin
      lock_arm_q <= i_wr.data[batmon_regs_pkg::NVC_LOCK_ARM];
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      block1_locked_q <= 1'b0;
      block0_locked_q <= 1'b0;
    end else if (lock_go) begin
      block1_locked_q <= block1_locked_q || i_lock_block1;
      block0_locked_q <= block0_locked_q || !i_lock_block1;
    end
  end

  // Power switch latch; a low pin wins over the clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ps_latch_q <= 1'b0;
    end else if (ps_lo) begin
      ps_latch_q <= 1'b1;
    end else if (wr_spf && i_wr.data[batmon_regs_pkg::SPF_POWER_SWITCH]) begin
      ps_latch_q <= 1'b0;
    end
  end

  // Pin driver bit; sleep releases it
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_io_q <= 1'b1;
    end else if (sleep_q) begin
      pin_io_q <= 1'b1;
    end else if (wr_spf) begin
      pin_io_q <= i_wr.data[batmon_regs_pkg::SPF_PIN_IO];
    end
  end

  // Swap selection
  assign o_swap_accept = i_swap_cmd && status_q[batmon_regs_pkg::STAT_SWAP_ENABLE];
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      swap_sel_q <= 1'b0;
    end else if (o_swap_accept) begin
      swap_sel_q <= i_swap_id_match;
    end
  end

  // Identifier opcode selection
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_read_id_opcode <= batmon_regs_pkg::OP_READ_ID_STD;
    end else begin
      o_read_id_opcode <= status_q[batmon_regs_pkg::STAT_ALT_READ_ID] ?
        batmon_regs_pkg::OP_READ_ID_ALT : batmon_regs_pkg::OP_READ_ID_STD;
    end
  end

  // Pin driver: interrupt or general output, released in sleep
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pin_io_oe <= 1'b0;
    end else if (sleep_q) begin
      o_pin_io_oe <= 1'b0;
    end else if (status_q[batmon_regs_pkg::STAT_IRQ_ENABLE]) begin
      o_pin_io_oe <= i_threshold_alarm;
    end else begin
      o_pin_io_oe <= !pin_io_q;
    end
  end
  assign o_pin_io = 1'b0;
  assign o_sleep = sleep_q;

  // Read data mux; reserved bits zero
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      unique case (i_rd_addr)
        batmon_regs_pkg::ADDR_PROTECTION_CTRL:
          o_rd_data <= {fault_q, o_charge_ctrl_n, o_discharge_ctrl_n, charge_en_q, discharge_en_q};
        batmon_regs_pkg::ADDR_CONFIG_STATUS:
          o_rd_data <= status_q;
        batmon_regs_pkg::ADDR_NV_MEMORY_CTRL:
          o_rd_data <= {copy_busy_q, lock_arm_q, 4'h0, block1_locked_q, block0_locked_q};
        batmon_regs_pkg::ADDR_SPECIAL_FEATURE:
          o_rd_data <= {!ps_latch_q, sleep_q | pio_in, swap_sel_q, 5'h00};
        default:
          o_rd_data <= '0;
      endcase
    end
  end

  // Named steps of the sleep and wake behaviour
  sequence s_wake_event;
    sleep_q && (bus_hi || ps_lo);
  endsequence
  sequence s_awake_enabled;
    !sleep_q && charge_en_q && discharge_en_q;
  endsequence
  sequence s_long_low;
    status_q[batmon_regs_pkg::STAT_SLEEP_ALLOW] && !sleep_q && !bus_hi && low_cnt_q >= SW'(SLEEP_CYCLES);
  endsequence

  // Protection register assertions
  a_fault_sticky: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_faults.over_voltage |=> fault_q[3]) else $error("fault flag not set");
  a_fault_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    fault_q[3] && !wr_prot |=> fault_q[3]) else $error("fault flag dropped without host");
  a_fault_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_prot && !i_wr.data[batmon_regs_pkg::PROT_OVER_VOLTAGE] && !i_faults.over_voltage |=> !fault_q[3])
    else $error("fault flag not cleared");
  a_recall_enables: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_recall.valid && !wake && !i_recall.prot_image[batmon_regs_pkg::PROT_CHARGE_ENABLE] |=> !charge_en_q)
    else $error("enable default not recalled");
  a_mirror_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd_addr == batmon_regs_pkg::ADDR_PROTECTION_CTRL |=>
      o_rd_data[batmon_regs_pkg::PROT_CHARGE_MIRROR] == $past(o_charge_ctrl_n)) else $error("charge mirror wrong");
  a_charge_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !charge_en_q |=> o_charge_ctrl_n) else $error("charge not forced off");
  a_discharge_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !discharge_en_q |=> o_discharge_ctrl_n) else $error("discharge not forced off");

  // Sleep and wake assertions
  a_wake_enables: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_wake_event |=> s_awake_enabled) else $error("wake did not set enables");
  a_sleep_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_long_low |=> sleep_q) else $error("long low bus did not sleep");
  a_no_sleep_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !status_q[batmon_regs_pkg::STAT_SLEEP_ALLOW] |=> !sleep_q) else $error("sleep while disabled");
  a_sleep_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    sleep_q |=> !o_pin_io_oe) else $error("pin driven in sleep");

  // Status register assertions
  a_recall_status: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_recall.valid |=> status_q == (($past(i_recall.status_image)) & batmon_regs_pkg::STAT_CFG_MASK))
    else $error("status not recalled");
  a_opcode_alt: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    status_q[batmon_regs_pkg::STAT_ALT_READ_ID] |=> o_read_id_opcode == batmon_regs_pkg::OP_READ_ID_ALT)
    else $error("alternate opcode not selected");
  a_status_ro: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_recall.valid |=> $stable(status_q)) else $error("status changed without recall");

  // Nonvolatile control assertions
  a_copy_block: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_copy_start |=> !o_nv_write_allow) else $error("copy did not block writes");
  a_lock_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_lock_cmd && !lock_arm_q |=> $stable({block1_locked_q, block0_locked_q})) else $error("unarmed lock acted");
  a_lock_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    lock_go |=> !lock_arm_q) else $error("lock arm not cleared");
  a_lock_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    lock_go && i_lock_block1 |=> block1_locked_q) else $error("block lock flag not set");
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd_addr == batmon_regs_pkg::ADDR_NV_MEMORY_CTRL |=> o_rd_data[5:2] == 4'h0) else $error("reserved bits set");

  // Special feature and pin assertions
  a_ps_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ps_lo |=> ps_latch_q) else $error("power switch not latched");
  a_ps_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ps_latch_q && i_rd_addr == batmon_regs_pkg::ADDR_SPECIAL_FEATURE |=>
      !o_rd_data[batmon_regs_pkg::SPF_POWER_SWITCH]) else $error("latched low does not read 0");
  a_pin_sense: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !sleep_q && i_rd_addr == batmon_regs_pkg::ADDR_SPECIAL_FEATURE |=>
      o_rd_data[batmon_regs_pkg::SPF_PIN_IO] == $past(pio_in)) else $error("pin sense wrong");
  a_swap_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_swap_cmd && !status_q[batmon_regs_pkg::STAT_SWAP_ENABLE] |=> $stable(swap_sel_q)) else $error("swap not gated");
  a_swap_select: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_swap_accept |=> swap_sel_q == $past(i_swap_id_match)) else $error("swap selection wrong");
  a_irq_pin: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !sleep_q && status_q[batmon_regs_pkg::STAT_IRQ_ENABLE] && i_threshold_alarm |=> o_pin_io_oe)
    else $error("interrupt did not pull pin");

endmodule

/* testbench/host_model.sv */
/*
  Host side model: issues whole-byte register writes and reads to the bank.
  Assumes the bench clock; changes its signals only at the falling edge.
*/
module host_model (
  // Clock
  input wire logic i_clock,
  // Register port towards the bank
  output batmon_regs_pkg::reg_write_t o_wr,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values
  initial begin
    o_wr = '0;
    o_rd_addr = 8'h00;
  end

  // One-cycle write pulse; released fields show the inverse, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_wr = '{valid: 1'b1, addr: a, data: d};
    @(negedge i_clock);
    o_wr = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask

  // Read data is registered, taken one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_rd_addr = a;
    @(negedge i_clock);
    d = i_rd_data;
  endtask

  // Re-arm the power switch latch right after seeing it at 0
  task automatic ps_service(output logic [7:0] d);
    rd(batmon_regs_pkg::ADDR_SPECIAL_FEATURE, d);
    if (d[batmon_regs_pkg::SPF_POWER_SWITCH] === 1'b0) begin
      wr(batmon_regs_pkg::ADDR_SPECIAL_FEATURE, 8'hc0);
    end
  endtask
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench of the register bank, one task per scenario.
  Assumes the host model drives the register port; all else is driven here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Design connections and bench state
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  batmon_regs_pkg::reg_write_t wr_s;
  batmon_regs_pkg::nv_recall_t rc = '0;
  batmon_regs_pkg::fault_events_t flt = '0;
  logic [7:0] rd_addr, rd_data, op, v;
  logic cp_s = 0, cp_d = 0, lk = 0, lk1 = 0, sw = 0, swm = 0;
  logic chp = 0, dchp = 0, thr = 0, bus = 1, psn = 1, pin = 1;
  logic nv_ok, sw_acc, pin_io_bit, pio_oe, cc_n, dc_n, slp;
  wire pin_w = pio_oe ? pin_io_bit : pin;
  int n_mismatch = 0;
  int comparisons = 0;

  // Clock at 125 MHz
  always #4 i_clock = ~i_clock;

  battery_monitor_ctrl_status_regs #(.SLEEP_CYCLES(20)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_wr(wr_s), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_recall(rc), .i_copy_start(cp_s),
    .i_copy_done(cp_d), .i_lock_cmd(lk), .i_lock_block1(lk1), .o_nv_write_allow(nv_ok),
    .i_swap_cmd(sw), .i_swap_id_match(swm), .o_swap_accept(sw_acc), .o_read_id_opcode(op),
    .i_faults(flt), .i_charge_protect(chp), .i_discharge_protect(dchp), .i_threshold_alarm(thr),
    .i_bus_line(bus), .i_power_switch_n(psn), .i_pin_io(pin_w), .o_pin_io(pin_io_bit),
    .o_pin_io_oe(pio_oe), .o_charge_ctrl_n(cc_n), .o_discharge_ctrl_n(dc_n), .o_sleep(slp));

  host_model host (.i_clock(i_clock), .o_wr(wr_s), .o_rd_addr(rd_addr), .i_rd_data(rd_data));

  // Comparison helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd(a, v);
    chk(v & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic rcl(input logic [7:0] p, input logic [7:0] s);
    @(negedge i_clock);
    rc = '{valid: 1'b1, prot_image: p, status_image: s};
    @(negedge i_clock);
    rc = '{valid: 1'b0, prot_image: ~p, status_image: ~s};
  endtask

  // Reset values, read-only status, reserved places
  task automatic t_reset();
    rdc(8'h01, 8'hff, 8'h00);
    chk(op, 8'h33);
    host.wr(8'h01, 8'hff);
    rdc(8'h01, 8'hff, 8'h00);
    rdc(8'h02, 8'hff, 8'h00);
    host.wr(8'h08, 8'hdf);
    rdc(8'h08, 8'h1f, 8'h00);
    $display("test reset done");
  endtask

  // Enable bits, control outputs and their mirrors
  task automatic t_enables();
    host.wr(8'h00, 8'h00);
    tick(1);
    chk({cc_n, dc_n}, 8'h03);
    rdc(8'h00, 8'h0f, 8'h0c);
    host.wr(8'h00, 8'h0f);
    tick(1);
    chk({cc_n, dc_n}, 8'h00);
    rdc(8'h00, 8'h0f, 8'h03);
    chp = 1;
    tick(4);
    chk({cc_n, dc_n}, 8'h02);
    chp = 0;
    dchp = 1;
    tick(4);
    chk({cc_n, dc_n}, 8'h01);
    dchp = 0;
    $display("test enables done");
  endtask

  // Each fault flag sticks until written 0
  task automatic t_faults();
    for (int i = 0; i < 4; i++) begin
      @(negedge i_clock);
      flt = 4'b1000 >> i;
      @(negedge i_clock);
      flt = '0;
      tick(4);
      rdc(8'h00, 8'hf0, 8'h80 >> i);
      host.wr(8'h00, 8'h03);
      rdc(8'h00, 8'hf0, 8'h00);
    end
    $display("test faults done");
  endtask

  // Block 1 recall, opcode choice and swap recognition
  task automatic t_recall();
    rcl(8'h02, 8'h3c);
    rdc(8'h01, 8'hff, 8'h3c);
    rdc(8'h00, 8'h03, 8'h02);
    chk(op, 8'h39);
    for (int e = 1; e >= 0; e--) begin
      @(negedge i_clock);
      sw = 1;
      swm = e[0];
      #1 chk({7'h00, sw_acc}, e[7:0]);
      @(negedge i_clock);
      sw = 0;
      rdc(8'h08, 8'h20, 8'h20);
      rcl(8'h03, 8'h00);
    end
    chk(op, 8'h33);
    $display("test recall done");
  endtask

  // Copy busy, lock arming and block lock flags
  task automatic t_nv();
    @(negedge i_clock);
    cp_s = 1;
    @(negedge i_clock);
    cp_s = 0;
    rdc(8'h07, 8'h80, 8'h80);
    chk({7'h00, nv_ok}, 8'h00);
    @(negedge i_clock);
    cp_d = 1;
    @(negedge i_clock);
    cp_d = 0;
    rdc(8'h07, 8'h80, 8'h00);
    chk({7'h00, nv_ok}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) host.wr(8'h07, 8'h40);
      @(negedge i_clock);
      lk = 1;
      lk1 = (k != 2);
      @(negedge i_clock);
      lk = 0;
      rdc(8'h07, 8'h43, (k == 0) ? 8'h00 : ((k == 1) ? 8'h02 : 8'h03));
    end
    host.wr(8'h07, 8'h00);
    rdc(8'h07, 8'h03, 8'h03);
    $display("test nv done");
  endtask

  // Power switch latch, pin sense and drive, interrupt use of the pin
  task automatic t_pins();
    host.wr(8'h08, 8'hc0);
    rdc(8'h08, 8'h80, 8'h80);
    psn = 0;
    tick(4);
    psn = 1;
    tick(4);
    rdc(8'h08, 8'h80, 8'h00);
    host.ps_service(v);
    rdc(8'h08, 8'h80, 8'h80);
    host.wr(8'h08, 8'h80);
    tick(2);
    chk({7'h00, pio_oe}, 8'h01);
    chk({7'h00, pin_io_bit}, 8'h00);
    rdc(8'h08, 8'h40, 8'h00);
    host.wr(8'h08, 8'hc0);
    tick(2);
    chk({7'h00, pio_oe}, 8'h00);
    pin = 0;
    tick(3);
    rdc(8'h08, 8'h40, 8'h00);
    pin = 1;
    tick(3);
    rdc(8'h08, 8'h40, 8'h40);
    rcl(8'h03, 8'h04);
    thr = 1;
    tick(4);
    chk({7'h00, pio_oe}, 8'h01);
    thr = 0;
    tick(4);
    chk({7'h00, pio_oe}, 8'h00);
    $display("test pins done");
  endtask

  // Sleep entry on a long low bus, wake sets both enables
  task automatic t_sleep();
    rcl(8'h03, 8'h00);
    bus = 0;
    tick(30);
    chk({7'h00, slp}, 8'h00);
    bus = 1;
    rcl(8'h03, 8'h20);
    host.wr(8'h00, 8'h00);
    host.wr(8'h08, 8'h80);
    bus = 0;
    tick(12);
    chk({7'h00, slp}, 8'h00);
    tick(20);
    chk({7'h00, slp}, 8'h01);
    chk({7'h00, pio_oe}, 8'h00);
    rdc(8'h08, 8'h40, 8'h40);
    bus = 1;
    tick(5);
    chk({7'h00, slp}, 8'h00);
    rdc(8'h00, 8'h03, 8'h03);
    $display("test sleep done");
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    tick(10);
    i_rst_n = 1'b1;
    t_reset();
    t_enables();
    t_faults();
    t_recall();
    t_nv();
    t_pins();
    t_sleep();
    close_out();
  end
endmodule
